// ---- bench/amp_chain_model.sv ----
`timescale 1ns/1ps
// ==========================================
// amplifier chain stand-in
module amp_chain_model (
	// clock
	input wire logic sys_clk,
	// levels and kinds the bench wants shown
	input wire logic [59:0] set_levels,
	input wire logic [59:0] set_kinds,
	// chain side of the block
	output logic [59:0] sensor_outputs,
	output logic [59:0] unit_kind
);
	// refresh per clock; no-switch units still show raw ones, so masking is the block's job
	always_ff @(posedge sys_clk) begin
		sensor_outputs <= set_levels;
		unit_kind <= set_kinds;
	end
endmodule

// ---- bench/objmap_props.sv ----
`timescale 1ns/1ps
// ==========================================
// object map checker
module objmap_props
	import objmap_pkg::*;
#(
	parameter int UNITS = NUM_UNITS
) (
	// top ports
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic obj_write,
	input wire logic obj_read,
	input wire logic [15:0] obj_index,
	input wire logic [7:0] obj_subindex,
	input wire logic [63:0] obj_wdata,
	input wire logic [63:0] obj_rdata,
	input wire logic obj_error,
	input wire logic [2*UNITS-1:0] sensor_outputs,
	input wire logic [2*UNITS-1:0] unit_kind,
	input wire logic [UNITS-1:0] unit_direction,
	input wire logic [3*UNITS-1:0] unit_mode_gain,
	input wire logic [UNITS-1:0] unit_preset
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// request decodes
	wire logic rd_b = obj_read && obj_index == IDX_INPUTS_BYTES;
	wire logic rd_w = obj_read && obj_index == IDX_INPUTS_WORDS;
	wire logic wr_1 = obj_write && obj_subindex == 8'h01;
	property p_byte_count; rd_b && obj_subindex == 8'h00 |=> obj_rdata[7:0] == 8'h08; endproperty
	a_byte_count: assert property (p_byte_count) else $error("byte count wrong");
	property p_word_count; rd_w && obj_subindex == 8'h00 |=> obj_rdata[7:0] == 8'h04; endproperty
	a_word_count: assert property (p_word_count) else $error("word count wrong");
	property p_byte_pack;
		rd_b && obj_subindex == 8'h02 && unit_kind[15:8] == 8'h00
		|=> obj_rdata[7:0] == $past(sensor_outputs[15:8]);
	endproperty
	a_byte_pack: assert property (p_byte_pack) else $error("byte packing wrong");
	property p_last_byte; rd_b && obj_subindex == 8'h08 |=> obj_rdata[7:4] == 4'h0; endproperty
	a_last_byte: assert property (p_last_byte) else $error("spare bits set");
	property p_no_switch;
		rd_b && obj_subindex == 8'h01 && unit_kind[3:2] == 2'b11 |=> obj_rdata[3:2] == 2'b00;
	endproperty
	a_no_switch: assert property (p_no_switch) else $error("no-switch unit not zero");
	property p_last_word; rd_w && obj_subindex == 8'h04 |=> obj_rdata[15:12] == 4'h0; endproperty
	a_last_word: assert property (p_last_word) else $error("spare word bits set");
	property p_dir_store;
		wr_1 && obj_index == IDX_DIRECTION + UNIT_STRIDE && obj_wdata[31:1] == 31'h0
		|-> ##2 unit_direction[1] == $past(obj_wdata[0], 2);
	endproperty
	a_dir_store: assert property (p_dir_store) else $error("direction not stored");
	property p_gain_hold;
		wr_1 && obj_index == IDX_MODE_GAIN && obj_wdata[31:0] >= 32'h8 ##1 !obj_write
		|=> $stable(unit_mode_gain[2:0]);
	endproperty
	a_gain_hold: assert property (p_gain_hold) else $error("unused code taken");
	property p_ro_error; obj_write && obj_index == IDX_INPUTS_BYTES |=> obj_error; endproperty
	a_ro_error: assert property (p_ro_error) else $error("input write not refused");
	property p_bulk_all;
		wr_1 && obj_index == IDX_BULK_PRESET && obj_wdata[61:0] == 62'h1 |-> ##2 &unit_preset;
	endproperty
	a_bulk_all: assert property (p_bulk_all) else $error("broadcast missed a unit");
endmodule
bind sensor_object_map_packer objmap_props #(.UNITS(UNITS)) objmap_props_inst (.*);

// ---- bench/test_sensor_object_map_packer.sv ----
`timescale 1ns/1ps
// ==========================================
// object map bench
module test_sensor_object_map_packer;
	import objmap_pkg::*;
	logic sys_clk, reset_n, obj_write, obj_read, obj_ack, obj_error, err;
	logic [15:0] obj_index;
	logic [7:0] obj_subindex;
	logic [63:0] obj_wdata, obj_rdata, got, img;
	logic [59:0] sensor_outputs, unit_kind, levels, kinds;
	logic [29:0] unit_direction, unit_preset;
	logic [89:0] unit_mode_gain;
	int errors, n_compared, cycles;
	sensor_object_map_packer sensor_object_map_packer_inst (.sys_clk(sys_clk),
		.reset_n(reset_n), .obj_write(obj_write), .obj_read(obj_read),
		.obj_index(obj_index), .obj_subindex(obj_subindex), .obj_wdata(obj_wdata),
		.obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_error(obj_error),
		.sensor_outputs(sensor_outputs), .unit_kind(unit_kind),
		.unit_direction(unit_direction), .unit_mode_gain(unit_mode_gain),
		.unit_preset(unit_preset));
	amp_chain_model amp_chain_model_inst (.sys_clk(sys_clk), .set_levels(levels),
		.set_kinds(kinds), .sensor_outputs(sensor_outputs), .unit_kind(unit_kind));
	// 100 MHz clock
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	// hang guard; a run needs about 80 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 1000) begin
			errors++;
			tally_and_finish();
		end
	end
	task check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one strobe, answer taken one edge later
	task xfer(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [63:0] d);
		@(posedge sys_clk);
		#1;
		obj_write = w;
		obj_read = !w;
		obj_index = i;
		obj_subindex = s;
		obj_wdata = d;
		@(posedge sys_clk);
		#1;
		obj_write = 0;
		obj_read = 0;
		got = obj_rdata;
		err = obj_error;
		check(obj_ack, 1);
	endtask
	task tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// main sequence; unit 2 lacks outputs, unit 30 is a differential amplifier
	initial begin
		{reset_n, obj_write, obj_read, obj_index, obj_subindex, obj_wdata} = '0;
		levels = 60'h9ab_cdef_0123_4567;
		kinds = {2'b10, 54'h0, 2'b11, 2'b00};
		img = {4'h0, levels & ~60'hc};
		repeat (20) @(posedge sys_clk);
		#1;
		reset_n = 1;
		xfer(0, IDX_INPUTS_BYTES, 8'h00, 0);
		check(got[7:0], 8'h08);
		check(err, 0);
		xfer(0, IDX_INPUTS_WORDS, 8'h00, 0);
		check(got[7:0], 8'h04);
		xfer(1, IDX_INPUTS_BYTES, 8'h01, 64'h1);
		check(err, 1);
		$display("test counts done");
		for (int k = 0; k < 8; k++) begin
			xfer(0, IDX_INPUTS_BYTES, 8'(k + 1), 0);
			check(got[7:0], img[8*k +: 8]);
		end
		for (int k = 0; k < 4; k++) begin
			xfer(0, IDX_INPUTS_WORDS, 8'(k + 1), 0);
			check(got[15:0], img[16*k +: 16]);
		end
		$display("test packing done");
		xfer(1, IDX_DIRECTION + UNIT_STRIDE, 8'h01, 64'h1);
		xfer(1, IDX_DIRECTION + UNIT_STRIDE, 8'h01, 64'h2);
		xfer(1, IDX_MODE_GAIN + 16'h0e80, 8'h01, 64'h7);
		xfer(1, IDX_MODE_GAIN, 8'h01, 64'h9);
		xfer(1, IDX_MODE_GAIN, 8'h01, 64'h2);
		xfer(1, IDX_PRESET, 8'h01, 64'h1);
		@(posedge sys_clk);
		#1;
		check(unit_direction[1], 1);
		check(unit_mode_gain[89:87], 3'h7);
		check(unit_mode_gain[2:0], 3'h0);
		check(unit_preset[0], 1);
		xfer(0, IDX_DIRECTION + UNIT_STRIDE, 8'h01, 0);
		check(got[15:0], 16'h1);
		check(err, 0);
		xfer(0, IDX_MODE_GAIN, 8'h01, 0);
		check(got[15:0], 16'h0);
		xfer(0, IDX_MODE_GAIN + 16'h0e80, 8'h01, 0);
		check(got[15:0], 16'h7);
		xfer(0, IDX_PRESET, 8'h00, 0);
		check(got[7:0], 8'h01);
		$display("test per-unit done");
		xfer(1, IDX_BULK_DIRECTION, 8'h01, 64'h2000_0001_0000_0001);
		xfer(1, IDX_BULK_PRESET, 8'h01, 64'h1);
		xfer(1, IDX_BULK_MODE_GAIN, 8'h01, 64'h2);
		@(posedge sys_clk);
		#1;
		check(unit_direction, 30'h2000_0003);
		check(unit_preset, 30'h3fff_ffff);
		check(unit_mode_gain[89:87], 3'h2);
		check(unit_mode_gain[2:0], 3'h0);
		$display("test bulk done");
		tally_and_finish();
	end
endmodule

// ---- rtl/input_packer.sv ----
`timescale 1ns/1ps
module input_packer
	import objmap_pkg::*;
#(
	parameter int UNITS = NUM_UNITS
) (
	// sensor side
	input wire logic [2*UNITS-1:0] raw_outputs,
	input wire logic [UNITS-1:0] no_switch_mask,
	// packed image
	output logic [63:0] packed_image
);
	// elaboration guard; the fixed 64-bit image needs at least two spare bits
	if (UNITS < 1 || UNITS > 31) begin : g_bad_units
		$error("input_packer: UNITS out of range");
	end
	genvar u;
	// ==========================================================
	// two bits per unit
	generate
		for (u = 0; u < UNITS; u++) begin : g_unit
			assign packed_image[2*u+1:2*u] = no_switch_mask[u] ? 2'b00 : raw_outputs[2*u+1:2*u];
		end
	endgenerate
	assign packed_image[63:2*UNITS] = '0;
endmodule

// ---- rtl/objmap_pkg.sv ----
// Functional notes
// - per-unit direction object, 16 bits RW, 0 normal, 1 reversed
// - per-unit mode/gain object; contact type 0..1, differential amplifier gain codes 0..7
// - per-unit preset object, 0 cleared, 1 executed
// - bulk word low 32 bits carry the value for the addressed object
// - bulk word bits 32..61 select units, value applied where bit set
// - all-zero selection applies value to units 1 through 30
// - bulk objects share range and default of matching per-unit object
// - byte input object reports count 8, then eight read-only bytes
// - each byte packs four units, output 1 then output 2, ascending
// - upper four bits of last byte are unused and read zero
// - units without switching outputs report both bits as zero
// - word input object reports count 4, then four read-only words
// - word layout same order; fourth word bits 12..15 unused
package objmap_pkg;
	// ==========================================================
	// object indices
	localparam logic [15:0] IDX_DIRECTION = 16'h4071;
	localparam logic [15:0] IDX_MODE_GAIN = 16'h1072;
	localparam logic [15:0] IDX_PRESET = 16'h4075;
	localparam logic [15:0] IDX_BULK_DIRECTION = 16'h4f71;
	localparam logic [15:0] IDX_BULK_MODE_GAIN = 16'h1f72;
	localparam logic [15:0] IDX_BULK_PRESET = 16'h4f75;
	localparam logic [15:0] IDX_INPUTS_BYTES = 16'h6000;
	localparam logic [15:0] IDX_INPUTS_WORDS = 16'h6100;
	localparam logic [15:0] UNIT_STRIDE = 16'h0080;
	// ==========================================================
	// counts and codes
	localparam int NUM_UNITS = 30;
	localparam logic [7:0] BYTE_ENTRIES = 8'h08;
	localparam logic [7:0] WORD_ENTRIES = 8'h04;
	localparam logic [7:0] SUB_ONE_ENTRIES = 8'h01;
	localparam logic [15:0] DIR_MAX = 16'h0001;
	localparam logic [15:0] CONTACT_MODE_MAX = 16'h0001;
	localparam logic [15:0] GAIN_MAX = 16'h0007;
	localparam logic [15:0] PRESET_MAX = 16'h0001;
	localparam logic [15:0] SETTING_RESET = 16'h0000;
	localparam int BULK_SEL_LSB = 32;
	// ==========================================================
	// amplifier kinds
	typedef enum logic [1:0] {
		kind_plain = 2'b00,
		kind_contact = 2'b01,
		kind_diff_amp = 2'b10,
		kind_no_switch = 2'b11
	} unit_kind_t;
endpackage

// ---- rtl/sensor_object_map_packer.sv ----
`timescale 1ns/1ps
module sensor_object_map_packer
	import objmap_pkg::*;
#(
	parameter int UNITS = NUM_UNITS
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// object access from the fieldbus master
	input wire logic obj_write,
	input wire logic obj_read,
	input wire logic [15:0] obj_index,
	input wire logic [7:0] obj_subindex,
	input wire logic [63:0] obj_wdata,
	output logic [63:0] obj_rdata,
	output logic obj_ack,
	output logic obj_error,
	// amplifier chain side
	input wire logic [2*UNITS-1:0] sensor_outputs,
	input wire logic [2*UNITS-1:0] unit_kind,
	output logic [UNITS-1:0] unit_direction,
	output logic [3*UNITS-1:0] unit_mode_gain,
	output logic [UNITS-1:0] unit_preset
);
	// elaboration guard; the bulk bitmap only names thirty units
	if (UNITS < 1 || UNITS > 30) begin : g_bad_units
		$error("UNITS must be 1..30");
	end

	// ==========================================================
	// setting stores, one entry per unit
	logic [15:0] dir_mem [UNITS];
	logic [15:0] mode_mem [UNITS];
	logic [15:0] preset_mem [UNITS];

	// ==========================================================
	// index decode
	// per-unit index from base and stride
	function automatic logic [5:0] unit_of(input logic [15:0] idx, input logic [15:0] base);
		logic [15:0] diff;
		diff = idx - base;
		// all ones never matches a unit, so stray indices select nothing
		if (idx >= base && diff[6:0] == 7'h00 && diff[15:7] < 9'(UNITS))
			unit_of = {1'b0, diff[11:7]};
		else
			unit_of = 6'h3f;
	endfunction

	// code legal for this unit kind
	function automatic logic code_ok(input logic [1:0] kind, input logic [15:0] code, input logic [1:0] obj);
		// every kind but the amplifier shares the two-code mode range
		case (obj)
			2'd0: code_ok = code <= DIR_MAX;
			2'd1: code_ok = (kind == kind_diff_amp) ? code <= GAIN_MAX : code <= CONTACT_MODE_MAX;
			2'd2: code_ok = code <= PRESET_MAX;
			default: code_ok = 1'b0;
		endcase
	endfunction

	wire logic [5:0] dir_unit = unit_of(obj_index, IDX_DIRECTION);
	wire logic [5:0] mode_unit = unit_of(obj_index, IDX_MODE_GAIN);
	wire logic [5:0] preset_unit = unit_of(obj_index, IDX_PRESET);
	wire logic hit_dir = dir_unit != 6'h3f;
	wire logic hit_mode = mode_unit != 6'h3f;
	wire logic hit_preset = preset_unit != 6'h3f;
	wire logic hit_bulk_dir = obj_index == IDX_BULK_DIRECTION;
	wire logic hit_bulk_mode = obj_index == IDX_BULK_MODE_GAIN;
	wire logic hit_bulk_preset = obj_index == IDX_BULK_PRESET;
	wire logic hit_bytes = obj_index == IDX_INPUTS_BYTES;
	wire logic hit_words = obj_index == IDX_INPUTS_WORDS;
	wire logic hit_single = hit_dir | hit_mode | hit_preset;
	wire logic hit_bulk = hit_bulk_dir | hit_bulk_mode | hit_bulk_preset;
	wire logic [4:0] single_unit = hit_dir ? dir_unit[4:0] :
		hit_mode ? mode_unit[4:0] : preset_unit[4:0];
	wire logic [1:0] obj_sel = (hit_dir | hit_bulk_dir) ? 2'd0 :
		(hit_mode | hit_bulk_mode) ? 2'd1 : 2'd2;

	// ==========================================================
	// bulk word split
	// value in low 32 bits
	wire logic [15:0] bulk_value = obj_wdata[15:0];
	// objects are 16 bits wide; a value using the upper half cannot fit and is dropped
	wire logic value_fits = obj_wdata[31:16] == 16'h0000;
	wire logic [29:0] bulk_map = obj_wdata[BULK_SEL_LSB+29:BULK_SEL_LSB];
	// top bits are the master's to keep zero, not checked
	wire logic [29:0] bulk_targets = (bulk_map == 30'h0) ? {30{1'b1}} : bulk_map;
	wire logic [15:0] single_value = obj_wdata[15:0];

	// ==========================================================
	// packed inputs
	logic [63:0] packed_image;
	wire logic [UNITS-1:0] no_switch;
	input_packer #(.UNITS(UNITS)) input_packer_inst (
		.raw_outputs(sensor_outputs),
		.no_switch_mask(no_switch),
		.packed_image(packed_image)
	);
	genvar g;
	generate
		for (g = 0; g < UNITS; g++) begin : g_kind
			assign no_switch[g] = unit_kind[2*g+1:2*g] == kind_no_switch;
		end
	endgenerate

	// ==========================================================
	// read mux, combinational
	logic [63:0] next_rdata;
	logic next_err;
	always_comb begin
		next_rdata = 64'h0;
		next_err = 1'b0;
		if (hit_single) begin
			if (obj_subindex == 8'h00)
				next_rdata = {56'h0, SUB_ONE_ENTRIES};
			else if (obj_subindex == 8'h01) begin
				case (obj_sel)
					2'd0: next_rdata = {48'h0, dir_mem[single_unit]};
					2'd1: next_rdata = {48'h0, mode_mem[single_unit]};
					default: next_rdata = {48'h0, preset_mem[single_unit]};
				endcase
			end else
				next_err = 1'b1;
		end else if (hit_bulk) begin
			// broadcast objects keep no value of their own; subindex 1 reads zero
			if (obj_subindex == 8'h00)
				next_rdata = {56'h0, SUB_ONE_ENTRIES};
			else if (obj_subindex != 8'h01)
				next_err = 1'b1;
		end else if (hit_bytes) begin
			if (obj_subindex == 8'h00)
				next_rdata = {56'h0, BYTE_ENTRIES};
			else if (obj_subindex <= BYTE_ENTRIES)
				next_rdata = {56'h0, packed_image[8*(obj_subindex-8'h01) +: 8]};
			else
				next_err = 1'b1;
		end else if (hit_words) begin
			if (obj_subindex == 8'h00)
				next_rdata = {56'h0, WORD_ENTRIES};
			else if (obj_subindex <= WORD_ENTRIES)
				next_rdata = {48'h0, packed_image[16*(obj_subindex-8'h01) +: 16]};
			else
				next_err = 1'b1;
		end else
			next_err = 1'b1;
	end

	// ==========================================================
	// write legality; read-only objects and bad subindex refuse writes
	wire logic single_ok = hit_single && obj_subindex == 8'h01;
	wire logic bulk_ok = hit_bulk && obj_subindex == 8'h01;
	// refused codes are acked without error; the master reads back to confirm
	wire logic write_err = !(single_ok || bulk_ok);

	// ==========================================================
	// per-unit write enables
	wire logic [UNITS-1:0] unit_take;
	genvar w;
	generate
		for (w = 0; w < UNITS; w++) begin : g_take
			// one range check for single and bulk
			assign unit_take[w] = obj_write && value_fits &&
				((single_ok && single_unit == 5'(w)) || (bulk_ok && bulk_targets[w])) &&
				code_ok(unit_kind[2*w+1 -: 2], single_value, obj_sel);
		end
	endgenerate

	// ==========================================================
	// setting stores; reset to default zero
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < UNITS; i++) begin
			if (!reset_n) begin
				dir_mem[i] <= SETTING_RESET;
				mode_mem[i] <= SETTING_RESET;
				preset_mem[i] <= SETTING_RESET;
			end else if (unit_take[i]) begin
				case (obj_sel)
					2'd0: dir_mem[i] <= bulk_value;
					2'd1: mode_mem[i] <= bulk_value;
					default: preset_mem[i] <= bulk_value;
				endcase
			end
		end
	end

	// ==========================================================
	// answers and settings outputs, all registered
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			obj_rdata <= 64'h0;
			obj_ack <= 1'b0;
			obj_error <= 1'b0;
		end else begin
			obj_ack <= obj_read | obj_write;
			// error rides with ack so each strobe gets exactly one answer
			obj_error <= (obj_read & next_err) | (obj_write & write_err);
			if (obj_read)
				obj_rdata <= next_rdata;
		end
	end

	// settings to the chain; only low code bits leave, stores keep 16 for read-back
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < UNITS; i++) begin
			if (!reset_n) begin
				unit_direction[i] <= 1'b0;
				unit_mode_gain[3*i +: 3] <= 3'h0;
				unit_preset[i] <= 1'b0;
			end else begin
				unit_direction[i] <= dir_mem[i][0];
				unit_mode_gain[3*i +: 3] <= mode_mem[i][2:0];
				unit_preset[i] <= preset_mem[i][0];
			end
		end
	end
endmodule
